// >>> src/cmo_unit.v
// Purpose: compare-match output unit with embedded pulse counter
// Assumes: 100 MHz clock; pulse input from a pin, count kept internally
// Notes:   list rescanned one entry per cycle on each new count
`timescale 1ns/10ps
`include "cmo_defs.vh"
// Behaviour
// - count equal to match value drives output per the output action
// - while valid, every new count value is compared again
// - further matches while asserted cause no new low-high edge
// - nonzero hold setting releases output after setting times 0.1 ms
// - zero hold setting keeps output asserted until software release or stop
// - after release, output asserts again only on a fresh match
// - list mode compares entries 0 to length-1, up to 256
// - while one entry's pulse runs, other entry matches are ignored
// - simultaneous list matches give one pulse of one hold period
// - action set drives high, action reset drives low
// - parameter error raises fault, stops, and reports a fault code
// - direction select sampled on run rise; low counts up
// - edge select sampled on run rise; chooses counted edge
// - match, hold and action latched on run rise while inactive
// - active set on run rise, cleared on run fall or fault
module cmo_unit (
	input  wire                    clk,         // system clock
	input  wire                    rst,         // sync reset, high
	input  wire                    ce,          // clock enable
	input  wire                    pulse_in,    // counted pin, async
	input  wire [3:0]              addr,        // register address
	input  wire [`CMO_CNT_W-1:0]   wdata,       // write data
	input  wire                    wr,          // write strobe
	input  wire                    rd,          // read strobe
	output reg  [`CMO_CNT_W-1:0]   rdata_q,     // read data
	output reg                     match_out_q, // digital output
	output reg                     valid_q,     // result valid
	output reg                     active_q,    // active flag
	output reg                     fault_q,     // fault flag
	output reg  [`CMO_ERR_W-1:0]   fault_code_q,// fault code
	output reg                     irq_q        // interrupt level
);
	////////////////////////////////////////////////////////////////
	// register file state
	reg                      run_q;       // run request
	reg                      list_mode_q; // compare against list
	reg                      dir_cfg_q;   // direction select
	reg                      edge_cfg_q;  // edge select
	reg  [1:0]               act_cfg_q;   // output action
	reg  [`CMO_CNT_W-1:0]    match_cfg_q; // match value
	reg  [`CMO_HOLD_W-1:0]   hold_cfg_q;  // hold time setting
	reg  [`CMO_LEN_W-1:0]    len_cfg_q;   // list length
	reg  [`CMO_LIST_AW-1:0]  wr_idx_q;    // list write index
	reg  [`CMO_INT_W-1:0]    int_stat_q;  // sticky events
	reg  [`CMO_INT_W-1:0]    int_mask_q;  // event mask
	reg                      sw_rel_q;    // software release request
	// latched operating copies
	reg                      dir_q;
	reg                      edge_q;
	reg  [1:0]               act_q;
	reg  [`CMO_CNT_W-1:0]    match_q;
	reg  [`CMO_HOLD_W-1:0]   hold_q;
	reg  [`CMO_LEN_W-1:0]    len_q;
	reg                      list_q;
	// engine
	reg  [1:0]               state_q;
	reg                      run_d1_q;
	reg                      out_asserted_q;
	reg  [`CMO_CNT_W-1:0]    count_q;
	reg  [`CMO_CNT_W-1:0]    prev_count_q;
	reg  [`CMO_LIST_AW-1:0]  scan_q;
	reg                      scan_v_q;
	reg                      scan_on_q;
	reg  [`CMO_TICK_W-1:0]   tick_q;
	reg  [`CMO_HOLD_W-1:0]   hold_cnt_q;
	reg                      pin_s1_q;
	reg                      pin_s2_q;
	reg                      pin_s3_q;
	wire [`CMO_CNT_W-1:0]    list_val;
	wire                     run_rise;
	wire                     run_fall;
	wire                     pin_edge;
	wire                     single_hit;
	wire                     count_new;
	wire                     list_hit;
	wire                     hit;
	wire                     tick;
	wire                     hold_done;
	wire                     cfg_bad;
	wire                     rel_now;
	wire [`CMO_INT_W-1:0]    ev;

	////////////////////////////////////////////////////////////////
	// decode the parameter fault code
	function [`CMO_ERR_W-1:0] fault_of;
		input [1:0]            a;
		input [`CMO_LEN_W-1:0] l;
		input                  lm;
		begin
			if (a != `CMO_ACT_SET && a != `CMO_ACT_RESET) begin
				fault_of = `CMO_ERR_ACTION;
			end else if (lm && (l == {`CMO_LEN_W{1'b0}} ||
					l > `CMO_LIST_DEPTH)) begin
				fault_of = `CMO_ERR_LENGTH;
			end else begin
				fault_of = `CMO_ERR_NONE;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// list memory, scanned one entry per cycle
	cmo_list_mem u_mem (
		.clk   (clk),
		.ce    (ce),
		.we    (wr && addr == `CMO_A_LIST_DATA && !active_q),
		.waddr (wr_idx_q),
		.wdata (wdata),
		.raddr (scan_q),
		.rdata (list_val)
	);

	// pin sync, two flops before any use
	always @(posedge clk) begin
		if (rst) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
		end else if (ce) begin
			pin_s1_q <= pulse_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// combinational decode
	assign run_rise   = run_q && !run_d1_q;
	assign run_fall   = !run_q && run_d1_q;
	assign pin_edge   = edge_q ? (pin_s3_q && !pin_s2_q) :
		(!pin_s3_q && pin_s2_q);
	assign count_new  = count_q != prev_count_q;
	assign single_hit = !list_q && count_q == match_q
		&& count_new;
	assign list_hit   = list_q && scan_v_q && list_val == count_q;
	assign hit        = valid_q && !out_asserted_q &&
		(single_hit || list_hit);
	assign tick       = tick_q == `CMO_TICK_CYCLES - 1;
	assign hold_done  = hold_q != {`CMO_HOLD_W{1'b0}} && tick &&
		hold_cnt_q == hold_q - 1'b1;
	assign cfg_bad    = fault_of(act_cfg_q, len_cfg_q, list_mode_q)
		!= `CMO_ERR_NONE;
	assign rel_now    = sw_rel_q || hold_done;
	assign ev         = {fault_q == 1'b0 && run_rise && cfg_bad,
		out_asserted_q && rel_now, hit};

	////////////////////////////////////////////////////////////////
	// software register writes and reads
	always @(posedge clk) begin
		if (rst) begin
			run_q       <= 1'b0;
			list_mode_q <= 1'b0;
			dir_cfg_q   <= 1'b0;
			edge_cfg_q  <= 1'b0;
			act_cfg_q   <= `CMO_ACT_SET;
			match_cfg_q <= {`CMO_CNT_W{1'b0}};
			hold_cfg_q  <= {`CMO_HOLD_W{1'b0}};
			len_cfg_q   <= {`CMO_LEN_W{1'b0}};
			wr_idx_q    <= {`CMO_LIST_AW{1'b0}};
			int_mask_q  <= {`CMO_INT_W{1'b0}};
			int_stat_q  <= {`CMO_INT_W{1'b0}};
			sw_rel_q    <= 1'b0;
			rdata_q     <= {`CMO_CNT_W{1'b0}};
		end else if (ce) begin
			sw_rel_q <= 1'b0;
			// set wins over the read clear
			int_stat_q <= ((rd && addr == `CMO_A_INT_STAT) ?
				{`CMO_INT_W{1'b0}} : int_stat_q) | ev;
			if (wr) begin
				case (addr)
				`CMO_A_CTRL: begin
					run_q       <= wdata[0];
					list_mode_q <= wdata[1];
					dir_cfg_q   <= wdata[2];
					edge_cfg_q  <= wdata[3];
					act_cfg_q   <= wdata[5:4];
					sw_rel_q    <= wdata[6];
				end
				`CMO_A_MATCH:    match_cfg_q <= wdata;
				`CMO_A_HOLD:     hold_cfg_q  <= wdata[`CMO_HOLD_W-1:0];
				`CMO_A_LEN:      len_cfg_q   <= wdata[`CMO_LEN_W-1:0];
				`CMO_A_LIST_IDX: wr_idx_q    <= wdata[`CMO_LIST_AW-1:0];
				`CMO_A_LIST_DATA: wr_idx_q   <= wr_idx_q + 1'b1;
				`CMO_A_INT_MASK: int_mask_q  <= wdata[`CMO_INT_W-1:0];
				default: ;
				endcase
			end
			rdata_q <= {`CMO_CNT_W{1'b0}};
			if (rd) begin
				case (addr)
				`CMO_A_CTRL: rdata_q <= {25'h0, 1'b0, act_cfg_q,
					edge_cfg_q, dir_cfg_q, list_mode_q, run_q};
				`CMO_A_STATUS: rdata_q <= {24'h0, fault_code_q,
					out_asserted_q, fault_q, active_q, valid_q};
				`CMO_A_MATCH:    rdata_q <= match_cfg_q;
				`CMO_A_HOLD:     rdata_q <= {16'h0, hold_cfg_q};
				`CMO_A_LEN:      rdata_q <= {23'h0, len_cfg_q};
				`CMO_A_LIST_IDX: rdata_q <= {24'h0, wr_idx_q};
				`CMO_A_INT_STAT: rdata_q <= {29'h0, int_stat_q};
				`CMO_A_INT_MASK: rdata_q <= {29'h0, int_mask_q};
				`CMO_A_COUNT:    rdata_q <= count_q;
				default:         rdata_q <= {`CMO_CNT_W{1'b0}};
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// run control, latching, counter, fault
	always @(posedge clk) begin
		if (rst) begin
			run_d1_q     <= 1'b0;
			state_q      <= `CMO_ST_IDLE;
			active_q     <= 1'b0;
			valid_q      <= 1'b0;
			fault_q      <= 1'b0;
			fault_code_q <= `CMO_ERR_NONE;
			dir_q        <= 1'b0;
			edge_q       <= 1'b0;
			act_q        <= `CMO_ACT_SET;
			match_q      <= {`CMO_CNT_W{1'b0}};
			hold_q       <= {`CMO_HOLD_W{1'b0}};
			len_q        <= {`CMO_LEN_W{1'b0}};
			list_q       <= 1'b0;
			count_q      <= {`CMO_CNT_W{1'b0}};
			prev_count_q <= {`CMO_CNT_W{1'b1}};
		end else if (ce) begin
			run_d1_q <= run_q;
			case (state_q)
			`CMO_ST_IDLE: begin
				if (run_rise && !active_q) begin
					if (cfg_bad) begin
						fault_q      <= 1'b1;
						fault_code_q <= fault_of(act_cfg_q, len_cfg_q,
							list_mode_q);
						state_q      <= `CMO_ST_FAULT;
					end else begin
						dir_q    <= dir_cfg_q;
						edge_q   <= edge_cfg_q;
						act_q    <= act_cfg_q;
						match_q  <= match_cfg_q;
						hold_q   <= hold_cfg_q;
						len_q    <= len_cfg_q;
						list_q   <= list_mode_q;
						count_q  <= {`CMO_CNT_W{1'b0}};
						prev_count_q <= {`CMO_CNT_W{1'b1}};
						active_q <= 1'b1;
						state_q  <= `CMO_ST_ARMED;
					end
				end
			end
			`CMO_ST_ARMED: begin
				valid_q <= 1'b1;
				prev_count_q <= count_q;        // last compared count
				if (pin_edge) begin
					count_q <= dir_q ? count_q - 1'b1 :
						count_q + 1'b1;
				end
				if (run_fall) begin
					active_q <= 1'b0;
					valid_q  <= 1'b0;
					state_q  <= `CMO_ST_IDLE;
				end
			end
			`CMO_ST_FAULT: begin
				active_q <= 1'b0;
				valid_q  <= 1'b0;
				if (run_fall) begin
					fault_q      <= 1'b0;
					fault_code_q <= `CMO_ERR_NONE;
					state_q      <= `CMO_ST_IDLE;
				end
			end
			default: state_q <= `CMO_ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// list scan, output drive, hold timer, interrupt
	always @(posedge clk) begin
		if (rst) begin
			scan_q         <= {`CMO_LIST_AW{1'b0}};
			scan_v_q       <= 1'b0;
			scan_on_q      <= 1'b0;
			out_asserted_q <= 1'b0;
			match_out_q    <= 1'b0;
			tick_q         <= {`CMO_TICK_W{1'b0}};
			hold_cnt_q     <= {`CMO_HOLD_W{1'b0}};
			irq_q          <= 1'b0;
		end else if (ce) begin
			irq_q <= |(int_stat_q & int_mask_q);
			// one pass over entries 0..len-1 per new count, so a
			// released output is not re-hit by an unchanged count
			if (state_q == `CMO_ST_ARMED && list_q && count_new) begin
				scan_on_q <= 1'b1;
				scan_v_q  <= 1'b0;
				scan_q    <= {`CMO_LIST_AW{1'b0}};
			end else if (state_q == `CMO_ST_ARMED && scan_on_q) begin
				scan_on_q <= (scan_q != len_q - 1'b1);
				scan_v_q  <= 1'b1;
				scan_q    <= scan_q + 1'b1;
			end else begin
				scan_on_q <= 1'b0;
				scan_v_q  <= 1'b0;
				scan_q    <= {`CMO_LIST_AW{1'b0}};
			end
			if (hit) begin
				out_asserted_q <= 1'b1;
				match_out_q    <= (act_q == `CMO_ACT_SET);
				tick_q         <= {`CMO_TICK_W{1'b0}};
				hold_cnt_q     <= {`CMO_HOLD_W{1'b0}};
			end else if (out_asserted_q) begin
				if (rel_now || state_q != `CMO_ST_ARMED) begin
					out_asserted_q <= 1'b0;
					match_out_q    <= (act_q != `CMO_ACT_SET);
				end else if (hold_q != {`CMO_HOLD_W{1'b0}}) begin
					if (tick) begin
						tick_q     <= {`CMO_TICK_W{1'b0}};
						hold_cnt_q <= hold_cnt_q + 1'b1;
					end else begin
						tick_q <= tick_q + 1'b1;
					end
				end
			end
		end
	end
endmodule

// >>> src/cmo_defs.vh
// Purpose: constants for the counter match output unit
// Assumes: 100 MHz system clock
// Notes:   times are in ns, counts derived from them
`ifndef CMO_DEFS_VH
`define CMO_DEFS_VH
`define CMO_CLK_PERIOD_NS   10
`define CMO_TICK_NS         100000
`define CMO_TICK_CYCLES     (`CMO_TICK_NS / `CMO_CLK_PERIOD_NS)
`define CMO_TICK_W          14
`define CMO_HOLD_W          16
`define CMO_CNT_W           32
`define CMO_LIST_DEPTH      256
`define CMO_LIST_AW         8
`define CMO_LEN_W           9
`define CMO_ACT_SET         2'h1
`define CMO_ACT_RESET       2'h2
`define CMO_ERR_W           4
`define CMO_ERR_NONE        4'h0
`define CMO_ERR_ACTION      4'h1
`define CMO_ERR_LENGTH      4'h2
`define CMO_ST_IDLE         2'h0
`define CMO_ST_ARMED        2'h1
`define CMO_ST_HELD         2'h2
`define CMO_ST_FAULT        2'h3
`define CMO_INT_W           3
`define CMO_EV_MATCH        0
`define CMO_EV_RELEASE      1
`define CMO_EV_FAULT        2
`define CMO_A_CTRL          4'h0
`define CMO_A_STATUS        4'h1
`define CMO_A_MATCH         4'h2
`define CMO_A_HOLD          4'h3
`define CMO_A_LEN           4'h4
`define CMO_A_LIST_IDX      4'h5
`define CMO_A_LIST_DATA     4'h6
`define CMO_A_INT_STAT      4'h7
`define CMO_A_INT_MASK      4'h8
`define CMO_A_COUNT         4'h9
`endif

// >>> src/cmo_list_mem.v
// Purpose: match value list storage, registered read
// Assumes: one write port, one read port, same clock
// Notes:   read data appear one cycle after the address
`timescale 1ns/10ps
`include "cmo_defs.vh"
module cmo_list_mem (
	input  wire                       clk,   // system clock
	input  wire                       ce,    // clock enable
	input  wire                       we,    // write strobe
	input  wire [`CMO_LIST_AW-1:0]    waddr, // write index
	input  wire [`CMO_CNT_W-1:0]      wdata, // write value
	input  wire [`CMO_LIST_AW-1:0]    raddr, // read index
	output reg  [`CMO_CNT_W-1:0]      rdata  // read value
);
	reg [`CMO_CNT_W-1:0] mem [0:`CMO_LIST_DEPTH-1];

	// write port and registered read
	always @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata <= mem[raddr];
		end
	end
endmodule

// >>> verification/cmo_unit_assertions.sv
// Purpose: port checks for the counter match output unit
// Assumes: one clock, sync reset high, ce held high
// Notes:   bound to cmo_unit from the testbench top file
`timescale 1ns/10ps
`include "cmo_defs.vh"
module cmo_chk (
	input wire                  clk,          // clock
	input wire                  rst,          // reset
	input wire                  ce,           // enable
	input wire                  pulse_in,     // pin
	input wire [3:0]            addr,         // index
	input wire [`CMO_CNT_W-1:0] wdata,        // write data
	input wire                  wr,           // write
	input wire                  rd,           // read
	input wire [`CMO_CNT_W-1:0] rdata_q,      // read data
	input wire                  match_out_q,  // output
	input wire                  valid_q,      // valid
	input wire                  active_q,     // active
	input wire                  fault_q,      // fault
	input wire [`CMO_ERR_W-1:0] fault_code_q, // code
	input wire                  irq_q         // interrupt
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////
	// fault, activity and read data
	fault_code_a: assert property (
		fault_q |-> fault_code_q == `CMO_ERR_ACTION ||
			fault_code_q == `CMO_ERR_LENGTH)
		else $error("fault flag without a cause code");
	fault_halt_a: assert property (
		fault_q |-> !active_q && !valid_q)
		else $error("unit still running while faulted");
	valid_active_a: assert property (
		valid_q |-> active_q)
		else $error("valid without active");
	valid_rise_a: assert property (
		$rose(active_q) |=> valid_q || fault_q)
		else $error("valid late after start");
	active_rise_a: assert property (
		$rose(active_q) |-> $past(wr, 2) &&
			$past(addr, 2) == `CMO_A_CTRL && $past(wdata[0], 2))
		else $error("active rose without a run write");
	active_fall_a: assert property (
		$fell(active_q) && !fault_q |-> $past(wr, 2) &&
			$past(addr, 2) == `CMO_A_CTRL && !$past(wdata[0], 2))
		else $error("active fell without a stop write");
	fault_clear_a: assert property (
		$fell(fault_q) |-> $past(wr, 2) && !$past(wdata[0], 2))
		else $error("fault cleared without run fall");
	rdata_idle_a: assert property (
		!$past(rd) |-> rdata_q == 32'h0)
		else $error("read data outside the read slot");
	////////////////////////////////////////////////////////////////////
	// main scenarios
	cover property ($rose(match_out_q));
	cover property ($rose(fault_q));
	cover property ($fell(match_out_q) && valid_q);
endmodule

// >>> verification/cmo_pulse_src.sv
// Purpose: pulse source feeding the counted pin
// Assumes: bursts requested by a one-cycle go strobe
// Notes:   pin idles low, 4 cycles high and 4 low per pulse
`timescale 1ns/10ps
module cmo_pulse_src (
	input  wire       clk,  // system clock
	input  wire       go,   // start a burst
	input  wire [7:0] n,    // pulses in burst
	output reg        pin,  // counted pin
	output reg        busy  // burst running
);
	integer i;
	// burst generator with idle gap after each burst
	initial begin
		pin = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (go) begin
				busy <= 1'b1;
				for (i = 0; i < n; i = i + 1) begin
					repeat (4) @(posedge clk);
					pin <= 1'b1;
					repeat (4) @(posedge clk);
					pin <= 1'b0;
				end
				repeat (8) @(posedge clk);
				busy <= 1'b0;
			end
		end
	end
endmodule

// >>> verification/tb.sv
// Purpose: register level test of the counter match output unit
// Assumes: 100 MHz clock, ce tied high
// Notes:   hold tick of 10000 cycles makes one unit 0.1 ms
`timescale 1ns/10ps
`include "cmo_defs.vh"
module tb;
	reg                   clk = 1'b0;    // clock
	reg                   rst = 1'b1;    // reset
	reg  [3:0]            addr = 4'h0;   // index
	reg  [31:0]           wdata = 32'h0; // write data
	reg                   wr = 1'b0;     // write
	reg                   rd = 1'b0;     // read
	reg                   go = 1'b0;     // burst start
	reg  [7:0]            pn = 8'h0;     // burst size
	reg  [31:0]           rv = 32'h0;    // read value
	reg                   mo_q = 1'b0;   // output delayed
	integer               hi_n = 0;
	integer               last_hi = 0;
	integer               rises = 0;
	integer               fail_count = 0;
	integer               n_compared = 0;
	wire                  pin, busy, mo, vl, ac, ft, irq;
	wire [`CMO_CNT_W-1:0] rdata;
	wire [`CMO_ERR_W-1:0] fc;
	always #5 clk = ~clk;
	cmo_unit uut (.clk(clk), .rst(rst), .ce(1'b1), .pulse_in(pin),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata),
		.match_out_q(mo), .valid_q(vl), .active_q(ac), .fault_q(ft),
		.fault_code_q(fc), .irq_q(irq));
	cmo_pulse_src src (.clk(clk), .go(go), .n(pn), .pin(pin),
		.busy(busy));
	// output edge and pulse width monitor
	always @(posedge clk) begin
		mo_q <= mo;
		hi_n <= mo ? hi_n + 1 : 0;
		if (mo && !mo_q) rises <= rises + 1;
		if (!mo && mo_q) last_hi <= hi_n;
	end
	////////////////////////////////////////////////////////////////////
	task stop_test;
		begin
			$display("compared %0d mismatches %0d", n_compared, fail_count);
			if (fail_count == 0 && n_compared > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input [127:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("ERROR %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task wreg(input [3:0] a, input [31:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rreg(input [3:0] a);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 rv = rdata;
		end
	endtask
	task pulses(input [7:0] n);
		integer i;
		begin
			@(posedge clk);
			pn <= n;
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			@(posedge clk);
			for (i = 0; i < 4000 && busy; i = i + 1)
				@(posedge clk);
			if (busy) begin
				chk("burst", busy, 1'b0);
				stop_test;
			end
		end
	endtask
	task wait_mo(input v, input integer lim);
		integer i;
		begin
			for (i = 0; i < lim && mo !== v; i = i + 1)
				@(posedge clk);
			chk("mo_wait", mo, v);
			if (mo !== v) stop_test;
		end
	endtask
	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rreg(`CMO_A_STATUS);
		chk("status", rv, 32'h0);
		rreg(4'hf);
		chk("unmapped", rv, 32'h0);
		wreg(`CMO_A_INT_MASK, 32'h7);
		// single match, set action, no hold
		wreg(`CMO_A_MATCH, 32'h5);
		wreg(`CMO_A_HOLD, 32'h0);
		wreg(`CMO_A_CTRL, 32'h11);
		wreg(`CMO_A_MATCH, 32'h2);
		pulses(4);
		chk("early", mo, 1'b0);
		pulses(1);
		wait_mo(1'b1, 20);
		chk("irq", irq, 1'b1);
		pulses(3);
		chk("rises", rises, 1);
		chk("valid", vl, 1'b1);
		rreg(`CMO_A_COUNT);
		chk("count", rv, 32'h8);
		rreg(`CMO_A_INT_STAT);
		chk("intstat", rv, 32'h1);
		wreg(`CMO_A_CTRL, 32'h51);
		wait_mo(1'b0, 20);
		pulses(2);
		chk("rearm", rises, 1);
		rreg(`CMO_A_INT_STAT);
		chk("intrel", rv, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq_clr", irq, 1'b0);
		wreg(`CMO_A_CTRL, 32'h0);
		// count down, falling edge, reset action
		wreg(`CMO_A_MATCH, 32'hfffffffd);
		wreg(`CMO_A_CTRL, 32'h2d);
		pulses(3);
		wait_mo(1'b0, 20);
		rreg(`CMO_A_COUNT);
		chk("down", rv, 32'hfffffffd);
		rreg(`CMO_A_STATUS);
		chk("st_rst", rv, 32'hb);
		wreg(`CMO_A_CTRL, 32'h6d);
		wait_mo(1'b1, 20);
		wreg(`CMO_A_CTRL, 32'h0);
		// reset after the stop write brings the released output back low
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk("rst_out", mo, 1'b0);
		// list of three, hold of one tick
		wreg(`CMO_A_LEN, 32'h3);
		wreg(`CMO_A_LIST_IDX, 32'h0);
		wreg(`CMO_A_LIST_DATA, 32'h3);
		wreg(`CMO_A_LIST_DATA, 32'h4);
		wreg(`CMO_A_LIST_DATA, 32'h3);
		wreg(`CMO_A_LIST_DATA, 32'h9);
		wreg(`CMO_A_HOLD, 32'h1);
		wreg(`CMO_A_CTRL, 32'h13);
		rises = 0;
		pulses(4);
		wait_mo(1'b0, 12000);
		@(posedge clk);
		chk("width", last_hi >= 9999 && last_hi <= 10001, 1);
		pulses(5);
		chk("one_pulse", rises, 1);
		// faults with the fault interrupt masked
		wreg(`CMO_A_CTRL, 32'h0);
		wreg(`CMO_A_INT_MASK, 32'h3);
		rreg(`CMO_A_INT_STAT);
		wreg(`CMO_A_CTRL, 32'h31);
		wreg(`CMO_A_HOLD, 32'h0);
		chk("fault", {ft, ac, vl, irq}, 4'h8);
		chk("code", fc, `CMO_ERR_ACTION);
		rreg(`CMO_A_INT_STAT);
		chk("intflt", rv, 32'h4);
		rreg(`CMO_A_STATUS);
		chk("stflt", rv, 32'h14);
		wreg(`CMO_A_CTRL, 32'h0);
		wreg(`CMO_A_LEN, 32'h0);
		wreg(`CMO_A_CTRL, 32'h13);
		wreg(`CMO_A_HOLD, 32'h0);
		chk("code2", fc, `CMO_ERR_LENGTH);
		wreg(`CMO_A_CTRL, 32'h0);
		wreg(`CMO_A_HOLD, 32'h0);
		chk("fclr", {ft, fc}, 5'h0);
		stop_test;
	end
endmodule
bind cmo_unit cmo_chk chk_i (.clk(clk), .rst(rst), .ce(ce),
	.pulse_in(pulse_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata_q(rdata_q), .match_out_q(match_out_q), .valid_q(valid_q),
	.active_q(active_q), .fault_q(fault_q), .fault_code_q(fault_code_q),
	.irq_q(irq_q));
